// file: coe_bus_edge.sv
// Edge and start/stop detector for the serial bus lines
`timescale 1ns/1ns
`default_nettype none

module coe_bus_edge (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det,
  output logic      sda_lvl
);
  logic [1:0] scl_reg;
  logic [1:0] scl_next;
  logic [1:0] sda_reg;
  logic [1:0] sda_next;

  always_comb begin
    scl_next = {scl_reg[0], scl_in};
    sda_next = {sda_reg[0], sda_in};
  end

  // Idle bus level is high, so reset to high to avoid a false start
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      scl_reg <= 2'h3;
      sda_reg <= 2'h3;
    end else begin
      scl_reg <= scl_next;
      sda_reg <= sda_next;
    end
  end

  assign scl_rise  = scl_reg[0] & ~scl_reg[1];
  assign scl_fall  = ~scl_reg[0] & scl_reg[1];
  assign start_det = scl_reg[0] & scl_reg[1] & ~sda_reg[0] & sda_reg[1];
  assign stop_det  = scl_reg[0] & scl_reg[1] & sda_reg[0] & ~sda_reg[1];
  assign sda_lvl   = sda_reg[0];
endmodule

`default_nettype wire

// file: coe_host_model.sv
// Serial bus host model that block-writes the configuration bytes
`timescale 1ns/1ns
`default_nettype none

module coe_host_model (
  input  wire logic clk_sys,
  input  wire logic sda_line,
  output logic      scl_drv,
  output logic      sda_pull
);
  // ****************************************
  // Bus phases, each at least 5 cycles
  // ****************************************
  initial begin
    scl_drv = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic gap(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic put_byte(input logic [7:0] b, inout int acks);
    logic ack;
    for (int i = 7; i >= 0; i--) begin
      sda_pull <= ~b[i];
      gap(6);
      scl_drv <= 1'b1;
      gap(6);
      scl_drv <= 1'b0;
      gap(5);
    end
    // Release data so the device alone decides the ninth bit
    sda_pull <= 1'b0;
    gap(6);
    scl_drv <= 1'b1;
    gap(3);
    ack = ~sda_line;
    gap(3);
    scl_drv <= 1'b0;
    gap(5);
    acks += int'(ack);
  endtask

  task automatic frame(input logic [7:0] addr, input logic [7:0] d [4],
                       input int n, output int acks);
    acks = 0;
    @(posedge clk_sys);
    sda_pull <= 1'b1;
    gap(6);
    scl_drv <= 1'b0;
    gap(5);
    put_byte(addr, acks);
    put_byte(8'h00, acks);
    put_byte(8'(n), acks);
    for (int i = 0; i < n; i++) begin
      put_byte(d[i], acks);
    end
    sda_pull <= 1'b1;
    gap(6);
    scl_drv <= 1'b1;
    gap(6);
    sda_pull <= 1'b0;
    gap(6);
  endtask
endmodule

`default_nettype wire

// file: coe_pkg.sv
// Types shared by the output enable bank
package coe_pkg;
  typedef enum logic [2:0] {
    COE_IDLE,
    COE_RECV,
    COE_BYTE_DONE,
    COE_ACK,
    COE_IGNORE
  } coe_state_t;
endpackage

// file: coe_regs.svh
// Offsets, bus address and reset values of the output enable bank
`ifndef COE_REGS_SVH
`define COE_REGS_SVH

// Fixed 7-bit bus address, direction bit always zero
`define COE_BUS_ADDR     7'h69
// Byte positions in a transfer: address, command code, count, then data
`define COE_IDX_ADDR     6'h00
`define COE_IDX_DATA0    6'h03
`define COE_IDX_LAST     6'h3F
// Register offsets
`define COE_OFF_LOW      2'h0
`define COE_OFF_HIGH     2'h1
`define COE_OFF_EXTRA    2'h2
// Reset values: every implemented output enabled
`define COE_RST_LOW      8'h0F
`define COE_RST_HIGH     8'hF0
`define COE_RST_EXTRA    8'hC0
// Field positions
`define COE_LOW_A0       0
`define COE_HIGH_B0      4
`define COE_EXTRA_C0     6

`endif

// file: coe_top.sv
// Serial-loaded output enable bank gating the fanout clock outputs
`timescale 1ns/1ns
`default_nettype none
`include "coe_regs.svh"

module coe_top (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       clock_in,
  output logic            fanout_clk_a0,
  output logic            fanout_clk_a1,
  output logic            fanout_clk_a2,
  output logic            fanout_clk_a3,
  output logic            fanout_clk_b0,
  output logic            fanout_clk_b1,
  output logic            fanout_clk_b2,
  output logic            fanout_clk_b3,
  output logic            fanout_clk_c0,
  output logic            fanout_clk_c1,
  output logic [7:0]      cfg_low,
  output logic [7:0]      cfg_high,
  output logic [7:0]      cfg_extra
);
  // ****************************************************************
  // Bus line conditioning
  // ****************************************************************
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic sda_lvl;

  coe_bus_edge u_edge (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det),
    .sda_lvl   (sda_lvl)
  );

  // ****************************************************************
  // Slave receiver state
  // ****************************************************************
  coe_pkg::coe_state_t state_reg;
  coe_pkg::coe_state_t state_next;
  logic [2:0]          bit_cnt_reg;
  logic [2:0]          bit_cnt_next;
  logic [7:0]          shift_reg;
  logic [7:0]          shift_next;
  logic [5:0]          byte_idx_reg;
  logic [5:0]          byte_idx_next;
  logic                ack_reg;
  logic                ack_next;
  logic [7:0]          low_reg;
  logic [7:0]          low_next;
  logic [7:0]          high_reg;
  logic [7:0]          high_next;
  logic [7:0]          extra_reg;
  logic [7:0]          extra_next;
  logic                byte_end;
  logic [5:0]          data_pos;

  // Address byte matches when the top seven bits hit and it is a write
  function automatic logic addr_hit(input logic [7:0] b);
    addr_hit = (b[7:1] == `COE_BUS_ADDR) && !b[0];
  endfunction

  assign byte_end = (state_reg == coe_pkg::COE_BYTE_DONE) && scl_fall;
  assign data_pos = byte_idx_reg - `COE_IDX_DATA0;

  always_comb begin
    state_next    = state_reg;
    bit_cnt_next  = bit_cnt_reg;
    shift_next    = shift_reg;
    byte_idx_next = byte_idx_reg;
    ack_next      = ack_reg;
    low_next      = low_reg;
    high_next     = high_reg;
    extra_next    = extra_reg;
    if (stop_det) begin
      state_next = coe_pkg::COE_IDLE;
      ack_next   = 1'b0;
    end else if (start_det) begin
      // Repeated start also restarts the byte sequence
      state_next    = coe_pkg::COE_RECV;
      bit_cnt_next  = 3'h0;
      byte_idx_next = `COE_IDX_ADDR;
      ack_next      = 1'b0;
    end else begin
      case (state_reg)
        coe_pkg::COE_RECV: begin
          if (scl_rise) begin
            shift_next   = {shift_reg[6:0], sda_lvl};
            bit_cnt_next = bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
              state_next = coe_pkg::COE_BYTE_DONE;
            end
          end
        end
        coe_pkg::COE_BYTE_DONE: begin
          if (scl_fall) begin
            if (byte_idx_reg == `COE_IDX_ADDR && !addr_hit(shift_reg)) begin
              state_next = coe_pkg::COE_IGNORE;
            end else begin
              state_next = coe_pkg::COE_ACK;
              ack_next   = 1'b1;
              // Command code and count are not checked; bytes past the
              // third data byte are acknowledged and dropped
              case (data_pos)
                6'h00: low_next = shift_reg;
                6'h01: high_next = shift_reg;
                6'h02: extra_next = shift_reg;
                default: begin
                end
              endcase
              if (byte_idx_reg != `COE_IDX_LAST) begin
                byte_idx_next = byte_idx_reg + 6'h01;
              end
            end
          end
        end
        coe_pkg::COE_ACK: begin
          if (scl_fall) begin
            state_next   = coe_pkg::COE_RECV;
            bit_cnt_next = 3'h0;
            ack_next     = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg    <= coe_pkg::COE_IDLE;
      bit_cnt_reg  <= 3'h0;
      shift_reg    <= 8'h00;
      byte_idx_reg <= `COE_IDX_ADDR;
      ack_reg      <= 1'b0;
      low_reg      <= `COE_RST_LOW;
      high_reg     <= `COE_RST_HIGH;
      extra_reg    <= `COE_RST_EXTRA;
    end else begin
      state_reg    <= state_next;
      bit_cnt_reg  <= bit_cnt_next;
      shift_reg    <= shift_next;
      byte_idx_reg <= byte_idx_next;
      ack_reg      <= ack_next;
      low_reg      <= low_next;
      high_reg     <= high_next;
      extra_reg    <= extra_next;
    end
  end

  // Open drain: only ever pulls low, for the acknowledge bit
  assign sda_out   = 1'b0;
  assign sda_oe    = ack_reg;
  assign cfg_low   = low_reg;
  assign cfg_high  = high_reg;
  assign cfg_extra = extra_reg;

  // ****************************************************************
  // Output gating
  // ****************************************************************
  logic [9:0] out_reg;
  logic [9:0] out_next;
  logic [9:0] en_vec;

  // Gating is registered, so a disable never leaves a runt high pulse
  // longer than one system clock
  assign en_vec = {extra_reg[`COE_EXTRA_C0 +: 2],
                   high_reg[`COE_HIGH_B0 +: 4],
                   low_reg[`COE_LOW_A0 +: 4]};

  always_comb begin
    out_next = {10{clock_in}} & en_vec;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      out_reg <= 10'h000;
    end else begin
      out_reg <= out_next;
    end
  end

  assign fanout_clk_a0 = out_reg[0];
  assign fanout_clk_a1 = out_reg[1];
  assign fanout_clk_a2 = out_reg[2];
  assign fanout_clk_a3 = out_reg[3];
  assign fanout_clk_b0 = out_reg[4];
  assign fanout_clk_b1 = out_reg[5];
  assign fanout_clk_b2 = out_reg[6];
  assign fanout_clk_b3 = out_reg[7];
  assign fanout_clk_c0 = out_reg[8];
  assign fanout_clk_c1 = out_reg[9];

  // ****************************************************************
  // Checks
  // ****************************************************************
  addr_ack_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    byte_end && !start_det && !stop_det && byte_idx_reg == `COE_IDX_ADDR
    && addr_hit(shift_reg) |=> sda_oe && !sda_out)
    else $error("matching address not acknowledged");

  addr_nack_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    byte_end && byte_idx_reg == `COE_IDX_ADDR && !addr_hit(shift_reg)
    |=> !sda_oe [*2])
    else $error("foreign address acknowledged");

  shift_msb_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state_reg == coe_pkg::COE_RECV && scl_rise && !start_det && !stop_det
    |=> shift_reg[0] == $past(sda_lvl) && shift_reg[7:1] == $past(shift_reg[6:0]))
    else $error("bit not shifted in msb first");

  load_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    byte_end && !start_det && !stop_det && byte_idx_reg == `COE_IDX_DATA0
    |=> low_reg == $past(shift_reg))
    else $error("first data byte not stored in low group");

  cfg_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !byte_end |=> $stable(low_reg) && $stable(high_reg) && $stable(extra_reg))
    else $error("configuration changed without a data byte");

  surplus_drop_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    byte_end && byte_idx_reg > 6'h05 |=> $stable(extra_reg) && $stable(low_reg))
    else $error("surplus data byte was stored");

  off_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !low_reg[0] && !low_reg[3] |=> !fanout_clk_a0 && !fanout_clk_a3)
    else $error("disabled output not held low");

  // The flops still see reset at the release edge, so no attempt opens there
  run_high_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !sys_rst && high_reg[7] && high_reg[4]
    |=> fanout_clk_b3 == $past(clock_in) && fanout_clk_b0 == $past(clock_in))
    else $error("enabled high group output not following clock");

  run_extra_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !sys_rst && extra_reg[7] && !extra_reg[6]
    |=> fanout_clk_c1 == $past(clock_in) && !fanout_clk_c0)
    else $error("extra group gating wrong");
endmodule

`default_nettype wire

// file: testbench.sv
// Self-checking bench for the serial-loaded output enable bank
`timescale 1ns/1ns
`default_nettype none
`include "coe_regs.svh"

module testbench;
  logic        clk_sys;
  logic        sys_rst;
  logic        clock_in;
  logic        scl_drv;
  logic        sda_pull;
  logic        sda_out;
  logic        sda_oe;
  wire logic   sda_line;
  logic [9:0]  outs;
  logic [7:0]  cfg_low;
  logic [7:0]  cfg_high;
  logic [7:0]  cfg_extra;
  logic [7:0]  exp_r [3];
  logic [31:0] seed;
  logic [31:0] ck_seed;
  int          errors;
  int          checks_done;

  // ****************************************
  // Wiring
  // ****************************************
  // Open-drain data line with a pull-up
  assign sda_line = ~(sda_pull | (sda_oe & ~sda_out));

  coe_top uut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl_drv),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .clock_in(clock_in), .fanout_clk_a0(outs[0]), .fanout_clk_a1(outs[1]),
    .fanout_clk_a2(outs[2]), .fanout_clk_a3(outs[3]),
    .fanout_clk_b0(outs[4]), .fanout_clk_b1(outs[5]),
    .fanout_clk_b2(outs[6]), .fanout_clk_b3(outs[7]),
    .fanout_clk_c0(outs[8]), .fanout_clk_c1(outs[9]),
    .cfg_low(cfg_low), .cfg_high(cfg_high), .cfg_extra(cfg_extra));

  coe_host_model host (.clk_sys(clk_sys), .sda_line(sda_line),
    .scl_drv(scl_drv), .sda_pull(sda_pull));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic [9:0] exp_en();
    return {exp_r[2][7:6], exp_r[1][7:4], exp_r[0][3:0]};
  endfunction

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_outs(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_state();
    logic ci;
    cmp_byte(cfg_low, exp_r[0]);
    cmp_byte(cfg_high, exp_r[1]);
    cmp_byte(cfg_extra, exp_r[2]);
    repeat (16) begin
      @(posedge clk_sys);
      ci = clock_in;
      @(negedge clk_sys);
      cmp_outs(outs, {10{ci}} & exp_en());
    end
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    exp_r = '{`COE_RST_LOW, `COE_RST_HIGH, `COE_RST_EXTRA};
    @(posedge clk_sys);
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************
  // Stimulus
  // ****************************************
  initial clk_sys = 1'b0;
  always #2 clk_sys = ~clk_sys;

  // Random fanout input so gating is seen on both levels
  always @(posedge clk_sys) begin
    ck_seed <= xs(ck_seed);
    clock_in <= ck_seed[7];
  end

  initial begin
    // All frames need at most about 27000 cycles; over twice that means a hang
    repeat (60000) @(posedge clk_sys);
    errors++;
    end_sim();
  end

  initial begin
    logic [7:0] d [4];
    logic [7:0] addr;
    int n;
    int acks;
    sys_rst = 1'b1;
    clock_in = 1'b0;
    seed = 32'h2c6f;
    ck_seed = 32'h2c6f;
    errors = 0;
    checks_done = 0;
    do_reset();
    check_state();
    $display("test reset done");
    for (int k = 0; k < 24; k++) begin
      seed = xs(seed);
      n = (k < 4) ? k + 1 : int'(seed[1:0]) + 1;
      addr = (k % 6 == 5) ? {seed[15:9], seed[0]} : 8'hD2;
      if (k == 5 || (k % 6 == 5 && addr == 8'hD2))
        addr = 8'hD3;
      d[0] = seed[23:16] & 8'h0F;
      d[1] = seed[31:24] & 8'hF0;
      d[2] = seed[11:4] & 8'hC0;
      d[3] = seed[7:0];
      if (k == 2)
        d = '{8'h00, 8'h00, 8'h00, 8'hFF};
      host.frame(addr, d, n, acks);
      if (addr == 8'hD2) begin
        for (int i = 0; i < 3 && i < n; i++) begin
          exp_r[i] = d[i];
        end
      end
      cmp_byte(8'(acks), (addr == 8'hD2) ? 8'(n + 3) : 8'h00);
      check_state();
      $display("test frame %0d done", k);
      if (k == 12) begin
        do_reset();
        check_state();
        $display("test second reset done");
      end
    end
    end_sim();
  end
endmodule

`default_nettype wire
